// file: hw/mbas_defines.vh
`ifndef MBAS_DEFINES_VH
`define MBAS_DEFINES_VH
// ----------------------------------------
// bus cycle type codes
// ----------------------------------------
`define MBAS_CYC_INTA 3'h0
`define MBAS_CYC_IO_RD 3'h1
`define MBAS_CYC_IO_WR 3'h2
`define MBAS_CYC_HALT 3'h3
`define MBAS_CYC_FETCH 3'h4
`define MBAS_CYC_MEM_RD 3'h5
`define MBAS_CYC_MEM_WR 3'h6
`define MBAS_CYC_PASSIVE 3'h7
// ----------------------------------------
// bus states
// ----------------------------------------
`define MBAS_ST_IDLE 2'h0
`define MBAS_ST_T1 2'h1
`define MBAS_ST_T2 2'h2
`define MBAS_ST_T3 2'h3
// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define MBAS_ADDR_W 19
`define MBAS_CAS_LSB 13
`define MBAS_UPPER_LSB 16
`define MBAS_STATUS_VALUE 3'h0
`endif

// file: hw/mbas_state.v
`timescale 1ns/100ps
`include "mbas_defines.vh"
// ----------------------------------------
// bus state sequencer
// ----------------------------------------
module mbas_state (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire start,
  output reg [1:0] state_reg
);
  reg [1:0] state_next;
  // one address state then two data states
  always @* begin
    case (state_reg)
      `MBAS_ST_IDLE: state_next = start ? `MBAS_ST_T1 : `MBAS_ST_IDLE;
      `MBAS_ST_T1: state_next = `MBAS_ST_T2;
      `MBAS_ST_T2: state_next = `MBAS_ST_T3;
      `MBAS_ST_T3: state_next = start ? `MBAS_ST_T1 : `MBAS_ST_IDLE;
      default: state_next = `MBAS_ST_IDLE;
    endcase
  end
  // state register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= `MBAS_ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end
endmodule // mbas_state

// file: hw/mbas_bus.v
`timescale 1ns/100ps
`include "mbas_defines.vh"
module mbas_bus #(
  parameter BYTE_BUS = 0
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire req_valid,
  input wire [2:0] req_type,
  input wire [18:0] req_addr,
  input wire [15:0] req_wdata,
  input wire [2:0] req_cascade,
  input wire bus_hold,
  input wire low_power,
  input wire [15:0] shared_ad_in,
  output reg req_ready,
  output reg rdata_valid,
  output reg [15:0] rdata,
  output reg [2:0] upper_addr_status_out,
  output reg upper_addr_status_oe,
  output reg upper_addr_status_weak_hi,
  output reg [7:0] upper_address_byte,
  output reg [15:0] shared_ad_out,
  output reg [15:0] shared_ad_oe,
  output reg [2:0] bus_cycle_type_code
);
  localparam [15:0] LOW_MASK = BYTE_BUS ? 16'h00ff : 16'hffff;
  wire [1:0] st;
  reg [2:0] type_reg;
  reg [18:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [2:0] cas_reg;
  wire start = req_valid && !bus_hold && !low_power;
  wire is_wr = (type_reg == `MBAS_CYC_IO_WR) || (type_reg == `MBAS_CYC_MEM_WR);
  wire is_inta = (type_reg == `MBAS_CYC_INTA);
  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  mbas_state u_state (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(start),
    .state_reg(st)
  );
  // capture request when a start is taken in idle or T3, on the edge into T1
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      type_reg <= `MBAS_CYC_PASSIVE;
      addr_reg <= 19'h00000;
      wdata_reg <= 16'h0000;
      cas_reg <= 3'h0;
    end else if (clk_en && start && (st == `MBAS_ST_IDLE || st == `MBAS_ST_T3)) begin
      type_reg <= req_type;
      addr_reg <= req_addr;
      wdata_reg <= req_wdata;
      cas_reg <= req_cascade;
    end
  end
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // registered pins, hold overrides the cycle, low power drives pins only in the idle state and blocks a new start from idle or T3
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_addr_status_out <= 3'h7;
      upper_addr_status_oe <= 1'b0;
      upper_addr_status_weak_hi <= 1'b1; // weak high, left to far side
      upper_address_byte <= 8'h00;
      shared_ad_out <= 16'h0000;
      shared_ad_oe <= 16'h0000;
      bus_cycle_type_code <= `MBAS_CYC_PASSIVE;
      req_ready <= 1'b0;
      rdata_valid <= 1'b0;
      rdata <= 16'h0000;
    end else if (clk_en) begin
      upper_addr_status_weak_hi <= 1'b0;
      rdata_valid <= 1'b0;
      req_ready <= start && (st == `MBAS_ST_IDLE || st == `MBAS_ST_T3);
      if (bus_hold) begin
        upper_addr_status_oe <= 1'b0;
        shared_ad_oe <= 16'h0000;
        bus_cycle_type_code <= `MBAS_CYC_PASSIVE;
      end else if (low_power && st == `MBAS_ST_IDLE) begin
        upper_addr_status_out <= 3'h0;
        upper_addr_status_oe <= 1'b1;
        shared_ad_out <= 16'h0000;
        shared_ad_oe <= LOW_MASK | 16'he000;
        bus_cycle_type_code <= `MBAS_CYC_PASSIVE;
      end else begin
        upper_addr_status_oe <= 1'b1;
        case (st)
          `MBAS_ST_T1: begin
            // address phase
            upper_addr_status_out <= addr_reg[18:16];
            upper_address_byte <= addr_reg[15:8];
            shared_ad_out <= {addr_reg[15:13], addr_reg[12:0]} & (LOW_MASK | 16'he000);
            shared_ad_oe <= LOW_MASK | 16'he000;
            bus_cycle_type_code <= type_reg;
          end
          `MBAS_ST_T2, `MBAS_ST_T3: begin
            upper_addr_status_out <= `MBAS_STATUS_VALUE;
            bus_cycle_type_code <= `MBAS_CYC_PASSIVE; // passive in late states
            if (is_inta) begin
              shared_ad_out <= {cas_reg, 13'h0000};
              shared_ad_oe <= 16'he000;
            end else if (is_wr) begin
              shared_ad_out <= wdata_reg & (LOW_MASK | 16'he000);
              shared_ad_oe <= LOW_MASK | 16'he000;
            end else begin
              shared_ad_oe <= 16'h0000;
            end
            if (st == `MBAS_ST_T3 && !is_wr && type_reg != `MBAS_CYC_HALT) begin
              rdata <= shared_ad_in & LOW_MASK;
              rdata_valid <= 1'b1;
            end
          end
          default: begin
            shared_ad_oe <= 16'h0000;
            bus_cycle_type_code <= `MBAS_CYC_PASSIVE;
          end
        endcase
      end
    end
  end
endmodule // mbas_bus

// file: bench/mbas_props.sv
`timescale 1ns/100ps
module mbas_props (
  input wire ref_clk,
  input wire rst_n,
  input wire bus_hold,
  input wire [2:0] req_type,
  input wire [18:0] req_addr,
  input wire req_ready,
  input wire [2:0] upper_addr_status_out,
  input wire [7:0] upper_address_byte,
  input wire [15:0] shared_ad_out,
  input wire [15:0] shared_ad_oe,
  input wire [2:0] bus_cycle_type_code
);
  // pin relations, paused while in reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_rst_float: assert property (!$past(rst_n) |-> shared_ad_oe == 16'h0)
    else $error("reset");
  chk_hold_float: assert property (bus_hold |=> shared_ad_oe == 16'h0) else $error("hold");
  chk_ready_gap: assert property (req_ready |=> !req_ready [*2]) else $error("gap");
  chk_code_type: assert property (req_ready |=> bus_cycle_type_code == $past(req_type, 2))
    else $error("code");
  chk_code_idle: assert property (req_ready |=> ##1 bus_cycle_type_code == 3'h7)
    else $error("idle");
  chk_status_zero: assert property (req_ready |=> ##1 (upper_addr_status_out == 3'h0) [*2])
    else $error("status");
  chk_addr_low: assert property (req_ready |=> shared_ad_out == $past(req_addr[15:0], 2))
    else $error("addr");
  chk_addr_high: assert property (req_ready |=>
    upper_addr_status_out == $past(req_addr[18:16], 2)) else $error("high addr");
  chk_byte_whole: assert property (req_ready |=> ##1 $stable(upper_address_byte) [*2])
    else $error("byte");
  chk_byte_addr: assert property (req_ready |=>
    upper_address_byte == $past(req_addr[15:8], 2)) else $error("byte addr");
endmodule // mbas_props
bind mbas_bus mbas_props u_props (.*);

// file: bench/mbas_far_side.sv
`timescale 1ns/100ps
module mbas_far_side (
  input wire ref_clk,
  input wire [15:0] shared_ad_oe,
  output wire [15:0] shared_ad_in
);
  // a released bus is answered at once, so the read sample sees it;
  // while driven the model shows the inverse; upper pins never pulled
  assign shared_ad_in = (shared_ad_oe == 16'h0) ? 16'h5a3c : 16'ha5c3;
endmodule // mbas_far_side

// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg c = 1'b0, rn = 1'b0, v = 1'b0, h = 1'b0;
  reg [37:0] r = 38'h0;
  reg [37:0] rows [0:6];
  wire [15:0] ai, ao, oe, rd;
  wire rdy;
  integer n_mismatch = 0, checked = 0, i, k;
  // 10 MHz clock
  always #50 c = ~c;
  mbas_bus dut (.ref_clk(c), .rst_n(rn), .clk_en(1'b1), .req_valid(v), .req_type(r[37:35]),
    .req_addr(r[34:16]), .req_wdata(r[15:0]), .req_cascade(r[18:16]), .bus_hold(h),
    .low_power(1'b0), .shared_ad_in(ai), .req_ready(rdy), .rdata_valid(), .rdata(rd),
    .upper_addr_status_out(), .upper_addr_status_oe(), .upper_addr_status_weak_hi(),
    .upper_address_byte(), .shared_ad_out(ao), .shared_ad_oe(oe), .bus_cycle_type_code());
  mbas_far_side far (.ref_clk(c), .shared_ad_oe(oe), .shared_ad_in(ai));
  task cmp(input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) n_mismatch = n_mismatch + 1;
      if (g !== e) $display("mismatch %0t %h %h", $time, e, g);
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge c);
      #1;
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // cycle codes 0 to 6 once each (not passive), then hold and a reset in mid cycle
  initial begin
    for (i = 0; i < 7; i = i + 1)
      rows[i] = {i[2:0], ~(i[18:0] * 19'h2b3c5), 16'hc3a5};
    step(10);
    rn = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      r = rows[i];
      v = 1'b1;
      for (k = 0; k < 8 && rdy !== 1'b1; k = k + 1)
        step(1);
      if (k == 8) n_mismatch = n_mismatch + 1;
      if (k == 8) wrap_up;
      v = 1'b0;
      step(2);
      if (i == 0) cmp({13'h0, r[18:16]}, {13'h0, ao[15:13]});
      if (r[36:35] == 2'h2) cmp(r[15:0], ao);
      step(2);
      if (r[36:35] == 2'h1) cmp(16'h5a3c, rd);
    end
    h = 1'b1;
    v = 1'b1;
    step(3);
    cmp(16'h0, oe);
    h = 1'b0;
    step(2);
    rn = 1'b0;
    step(1);
    cmp(16'h0, oe);
    wrap_up;
  end
endmodule // tb_top
